/* File: printer_escape_interpreter.v */
// Operation
// - Form length n sets length n, margins 1..n, active line 1.
// - Margin command sets top and bottom; omitted first keeps top.
// - ESC J or ESC 3 sets vertical tab at active line.
// - CSI 1 g clears the vertical tab at active line only.
// - CSI 4 g or ESC 4 clears every vertical tab stop.
// - CSI v sets tabs at each listed line, up to 16 parameters.
// - ESC = enables alternate keypad mode, ESC > disables it.
// - British set prints pound sign for code 043.
// - National sets differ only at the listed code positions.
// - Character set follows the later of set-up or escape selection; an unknown ESC ( letter in the cycle of a set-up change keeps the old set.
// - Columns and lines count from one, never zero.
// - Printables advance column by one up to 255; line feed advances line by one, or wraps from the bottom margin to the top.
// - Active line moves forward, or back only to the top margin.
// - Head column is committed only when a character prints.
// - When idle, head column is that of the last print and can differ from the tracked column.
// - Bell carries only its active line.
// - Newline mode makes LF, VT and FF also return to left margin.
// - Set-up choice 2 enables newline mode; choices 1 or 3 disable.
// - Parameters are unsigned decimal, leading zeros ok, missing is zero.
// - CSI 20 h enables newline mode, CSI 20 l disables it.
// - Attributes request with no or zero parameter sends the answer.
// - ESC ( letter selects a national character set.
`timescale 1ns/1ps
`include "printer_escape_interpreter_defines.vh"

////////////////////////////////////////////////////////////////////////////
module char_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // Clock.
  input wire reset, // Synchronous reset.
  input wire [WIDTH-1:0] inData, // Write data.
  input wire inValid, // Write request.
  output wire inReady, // Room for a word.
  output wire [WIDTH-1:0] outData, // Oldest word.
  input wire outReady, // Reader takes the word.
  output wire outValid // A word is held.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire [AW:0] used = wrPtr_q - rdPtr_q;
  assign inReady = (used != DEPTH[AW:0]);
  assign outValid = (used != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q[AW-1:0]];
  // Pointers carry one extra bit so full and empty stay distinct.
  always @(posedge clk)
  begin
    if (reset)
    begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (inValid && inReady)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
  // Storage needs no reset; only words below the write pointer are read.
  always @(posedge clk)
  begin
    if (inValid && inReady)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module printer_escape_interpreter #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter [7:0] ID_CODE = 8'h37 // Arbitrary attribute class code.
) (
  input wire clk, // Clock, 200 MHz.
  input wire reset, // Synchronous reset, active high.
  input wire [7:0] rxData, // Received character.
  input wire rxValid, // Received character valid.
  output wire rxReady, // Buffer has room.
  output reg [7:0] printData, // Code to print.
  output reg [2:0] printSet, // Character set for it.
  output reg printNational, // Code prints a national glyph.
  output reg [7:0] printCol, // Column it prints at.
  output reg [7:0] printLine, // Line it prints on.
  output reg printValid, // Print request.
  input wire printReady, // Print mechanism takes it.
  output reg [7:0] txData, // Answer byte to host.
  output wire txValid, // Answer byte valid.
  input wire txReady, // Transmitter takes it.
  output reg bellPulse, // One-cycle bell.
  output reg [7:0] bellLine, // Line the bell belongs to.
  input wire [1:0] setupNewline, // Operator new line choice.
  input wire [2:0] setupCharset, // Operator character set.
  output reg keypadAlt, // Alternate keypad mode.
  output reg newlineMode, // Linefeed-newline mode.
  output reg [2:0] charSet, // Active character set.
  output reg [7:0] activeCol, // Active column.
  output reg [7:0] activeLine, // Active line.
  output reg [7:0] formLength, // Form length in lines.
  output reg [7:0] topMargin, // Top margin line.
  output reg [7:0] bottomMargin, // Bottom margin line.
  output reg [7:0] headCol, // Column last committed to the head.
  output reg [167:0] vtabStops, // Stop per line, bit 0 is line 1.
  output wire idle // Nothing pending.
);
  reg [2:0] state_q;
  reg [7:0] prm [0:15];
  reg [3:0] pIdx_q;
  reg [3:0] vIdx_q;
  reg [2:0] aIdx_q;
  reg digit_q;
  reg topOmit_q;
  reg priv_q;
  reg [1:0] nl1_q, nl2_q, nl3_q, nlLast_q;
  reg [2:0] cs1_q, cs2_q, cs3_q, csLast_q;
  integer i;
  wire [7:0] c;
  wire fifoValid;
  wire stall = printValid && !printReady;
  wire take = fifoValid && !stall && (state_q <= `ST_SCS
    || state_q == `ST_SKIP);

  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk),
    .reset(reset),
    .inData(rxData),
    .inValid(rxValid),
    .inReady(rxReady),
    .outData(c),
    .outReady(take),
    .outValid(fifoValid)
  );

  // Decimal digit accumulation, saturating so long numbers stay large.
  function [7:0] accDigit(input [7:0] acc, input [7:0] ch);
    reg [11:0] s;
    begin
      s = {4'h0, acc} * 12'h00a + {4'h0, ch - `CH_D0};
      accDigit = (s > 12'h0ff) ? 8'hff : s[7:0];
    end
  endfunction

  // Next line down; past the bottom margin it wraps to the top margin.
  function [7:0] nextLine(input [7:0] ln, input [7:0] tm, input [7:0] bm);
    begin
      nextLine = (ln >= bm) ? tm : ln + `LINE_ONE;
    end
  endfunction

  // Positions at which a national set may differ from US ASCII.
  function isNat(input [7:0] ch);
    begin
      isNat = ch == `NC_HASH || ch == `NC_AT || ch == `NC_GRAVE
        || (ch >= `NC_LO1 && ch <= `NC_HI1)
        || (ch >= `NC_LO2 && ch <= `NC_HI2);
    end
  endfunction

  // Answer bytes: escape, bracket, query, class code, final.
  function [7:0] ansByte(input [2:0] k);
    begin
      case (k)
        3'h0: ansByte = `CH_ESC;
        3'h1: ansByte = `CH_LBR;
        3'h2: ansByte = `CH_QM;
        3'h3: ansByte = ID_CODE;
        default: ansByte = `F_DA;
      endcase
    end
  endfunction

  wire [7:0] nl = nextLine(activeLine, topMargin, bottomMargin);
  wire [7:0] p0 = prm[0];
  wire [7:0] vp = prm[vIdx_q];
  // Margin candidates; an omitted first parameter keeps the top.
  wire [7:0] mTop = topOmit_q ? topMargin : p0;
  wire [7:0] mBot = (pIdx_q == 4'h0) ? bottomMargin : prm[1];
  wire mOk = mTop >= `LINE_ONE && mTop <= mBot && mBot <= formLength;
  wire printable = c >= `CH_BANG && c <= `CH_TILDE;
  wire colInc = activeCol != 8'hff;
  assign txValid = (state_q == `ST_TX);
  // Idle once the buffer and printer drain and the parser is in ground state.
  assign idle = state_q == `ST_GROUND && !fifoValid && !printValid;

  // Operator set-up inputs come from the panel; three flops each.
  always @(posedge clk)
  begin
    nl1_q <= setupNewline;
    nl2_q <= nl1_q;
    nl3_q <= nl2_q;
    cs1_q <= setupCharset;
    cs2_q <= cs1_q;
    cs3_q <= cs2_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interpreter. Set-up changes are applied first so that an escape
  // sequence taking effect in the same cycle counts as the later one.
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= `ST_GROUND;
      pIdx_q <= 4'h0;
      vIdx_q <= 4'h0;
      aIdx_q <= 3'h0;
      digit_q <= 1'b0;
      topOmit_q <= 1'b0;
      priv_q <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
        prm[i] <= 8'h00;
      nlLast_q <= 2'h0;
      csLast_q <= `CS_US;
      printData <= 8'h00;
      printSet <= `CS_US;
      printNational <= 1'b0;
      printCol <= `LINE_ONE;
      printLine <= `LINE_ONE;
      printValid <= 1'b0;
      txData <= 8'h00;
      bellPulse <= 1'b0;
      bellLine <= `LINE_ONE;
      keypadAlt <= 1'b0;
      newlineMode <= 1'b0;
      charSet <= `CS_US;
      activeCol <= `LINE_ONE;
      activeLine <= `LINE_ONE;
      formLength <= `FORM_RST;
      topMargin <= `LINE_ONE;
      bottomMargin <= `FORM_RST;
      headCol <= `LINE_ONE;
      vtabStops <= 168'h0;
    end
    else
    begin
      bellPulse <= 1'b0;
      if (printReady)
        printValid <= 1'b0;
      if (nl2_q == nl3_q && nl3_q != nlLast_q)
      begin
        nlLast_q <= nl3_q;
        newlineMode <= (nl3_q == `NL_CHOICE_LF);
      end
      if (cs2_q == cs3_q && cs3_q != csLast_q)
      begin
        csLast_q <= cs3_q;
        charSet <= cs3_q;
      end
      case (state_q)
        `ST_GROUND:
          if (take)
          begin
            case (c)
              `CH_ESC: state_q <= `ST_ESC;
              `CH_LF:
              begin
                activeLine <= nl;
                if (newlineMode)
                  activeCol <= `LINE_ONE;
              end
              `CH_VT:
              begin
                state_q <= `ST_VTAB;
                if (newlineMode)
                  activeCol <= `LINE_ONE;
              end
              `CH_FF:
              begin
                activeLine <= topMargin;
                if (newlineMode)
                  activeCol <= `LINE_ONE;
              end
              `CH_CR: activeCol <= `LINE_ONE;
              `CH_BS:
                if (activeCol > `LINE_ONE)
                  activeCol <= activeCol - `LINE_ONE;
              `CH_BEL:
              begin
                bellPulse <= 1'b1;
                bellLine <= activeLine;
              end
              `CH_SP:
                if (colInc)
                  activeCol <= activeCol + `LINE_ONE;
              default:
                if (printable)
                begin
                  printData <= c;
                  printSet <= charSet;
                  printNational <= charSet != `CS_US && isNat(c);
                  printCol <= activeCol;
                  printLine <= activeLine;
                  printValid <= 1'b1;
                  headCol <= activeCol;
                  if (colInc)
                    activeCol <= activeCol + `LINE_ONE;
                end
            endcase
          end
        `ST_ESC:
          if (take)
          begin
            state_q <= `ST_GROUND;
            case (c)
              `CH_LBR:
              begin
                state_q <= `ST_CSI;
                for (i = 0; i < 16; i = i + 1)
                  prm[i] <= 8'h00;
                pIdx_q <= 4'h0;
                digit_q <= 1'b0;
                topOmit_q <= 1'b0;
                priv_q <= 1'b0;
              end
              `CH_LPAR: state_q <= `ST_SCS;
              `F_VTSET, `F_VTSET_OLD:
                vtabStops[activeLine - `LINE_ONE] <= 1'b1;
              `F_VTCLR_OLD: vtabStops <= 168'h0;
              `CH_EQ: keypadAlt <= 1'b1;
              `CH_GT: keypadAlt <= 1'b0;
              default:
                if (c < `CH_D0)
                  state_q <= `ST_SKIP;
            endcase
          end
        `ST_SCS:
          if (take)
          begin
            state_q <= `ST_GROUND;
            case (c)
              `L_US: charSet <= `CS_US;
              `L_GB: charSet <= `CS_GB;
              `L_FI: charSet <= `CS_FI;
              `L_NO: charSet <= `CS_NO;
              `L_SE: charSet <= `CS_SE;
              `L_DE: charSet <= `CS_DE;
              `L_FR: charSet <= `CS_FR;
              default: charSet <= charSet;
            endcase
          end
        `ST_SKIP:
          if (take && c >= `CH_D0)
            state_q <= `ST_GROUND;
        `ST_CSI:
          if (take)
          begin
            if (c >= `CH_D0 && c <= `CH_D9)
            begin
              prm[pIdx_q] <= accDigit(prm[pIdx_q], c);
              digit_q <= 1'b1;
            end
            else if (c == `CH_SEMI)
            begin
              if (pIdx_q == 4'h0 && !digit_q)
                topOmit_q <= 1'b1;
              if (pIdx_q != 4'hf)
                pIdx_q <= pIdx_q + 4'h1;
              digit_q <= 1'b0;
            end
            else if (c == `CH_QM)
              priv_q <= 1'b1;
            else if (c >= `CH_FIN_LO && c <= `CH_TILDE)
            begin
              state_q <= `ST_GROUND;
              if (!priv_q)
                case (c)
                  `F_FORM:
                    if (p0 >= `LINE_ONE && p0 <= `MAX_LINES)
                    begin
                      formLength <= p0;
                      topMargin <= `LINE_ONE;
                      bottomMargin <= p0;
                      activeLine <= `LINE_ONE;
                    end
                  `F_MARG:
                    if (mOk)
                    begin
                      topMargin <= mTop;
                      bottomMargin <= mBot;
                    end
                  `F_TBC:
                    if (p0 == `PV_ONE)
                      vtabStops[activeLine - `LINE_ONE] <= 1'b0;
                    else if (p0 == `PV_ALL)
                      vtabStops <= 168'h0;
                  `F_VTS:
                  begin
                    state_q <= `ST_VSET;
                    vIdx_q <= 4'h0;
                  end
                  `F_DA:
                    if (p0 == 8'h00)
                    begin
                      state_q <= `ST_TX;
                      aIdx_q <= 3'h0;
                      txData <= ansByte(3'h0);
                    end
                  `F_SETM:
                    if (p0 == `PV_LNM)
                      newlineMode <= 1'b1;
                  `F_RSTM:
                    if (p0 == `PV_LNM)
                      newlineMode <= 1'b0;
                  default: state_q <= `ST_GROUND;
                endcase
            end
          end
        `ST_VSET:
        begin
          // One parameter per cycle; lines outside the stop range drop.
          if (vp >= `LINE_ONE && vp <= `MAX_LINES)
            vtabStops[vp - `LINE_ONE] <= 1'b1;
          if (vIdx_q == pIdx_q)
            state_q <= `ST_GROUND;
          vIdx_q <= vIdx_q + 4'h1;
        end
        `ST_TX:
          if (txReady)
          begin
            aIdx_q <= aIdx_q + 3'h1;
            txData <= ansByte(aIdx_q + 3'h1);
            if (aIdx_q == `LAST_ANS)
              state_q <= `ST_GROUND;
          end
        `ST_VTAB:
        begin
          // Step forward a line per cycle to the next stop or top margin.
          activeLine <= nl;
          if (vtabStops[nl - `LINE_ONE] || nl == topMargin)
            state_q <= `ST_GROUND;
        end
        default: state_q <= `ST_GROUND;
      endcase
    end
  end
endmodule

/* File: printer_escape_interpreter_defines.vh */
`ifndef PRINTER_ESCAPE_INTERPRETER_DEFINES_VH
`define PRINTER_ESCAPE_INTERPRETER_DEFINES_VH
// Parser states.
`define ST_GROUND 3'h0
`define ST_ESC 3'h1
`define ST_CSI 3'h2
`define ST_SCS 3'h3
`define ST_VSET 3'h4
`define ST_TX 3'h5
`define ST_VTAB 3'h6
`define ST_SKIP 3'h7
// Control and syntax characters.
`define CH_BEL 8'h07
`define CH_BS 8'h08
`define CH_LF 8'h0a
`define CH_VT 8'h0b
`define CH_FF 8'h0c
`define CH_CR 8'h0d
`define CH_ESC 8'h1b
`define CH_SP 8'h20
`define CH_BANG 8'h21
`define CH_TILDE 8'h7e
`define CH_LPAR 8'h28
`define CH_D0 8'h30
`define CH_D9 8'h39
`define CH_SEMI 8'h3b
`define CH_EQ 8'h3d
`define CH_GT 8'h3e
`define CH_QM 8'h3f
`define CH_LBR 8'h5b
`define CH_FIN_LO 8'h40
// Escape finals.
`define F_VTSET 8'h4a
`define F_VTSET_OLD 8'h33
`define F_VTCLR_OLD 8'h34
// Control sequence finals.
`define F_FORM 8'h74
`define F_MARG 8'h72
`define F_TBC 8'h67
`define F_VTS 8'h76
`define F_DA 8'h63
`define F_SETM 8'h68
`define F_RSTM 8'h6c
// Parameter values.
`define PV_ONE 8'h01
`define PV_ALL 8'h04
`define PV_LNM 8'h14
`define NL_CHOICE_LF 2'h2
// Character sets and their selecting letters.
`define CS_US 3'h0
`define CS_GB 3'h1
`define CS_FI 3'h2
`define CS_NO 3'h3
`define CS_SE 3'h4
`define CS_DE 3'h5
`define CS_FR 3'h6
`define L_US 8'h42
`define L_GB 8'h41
`define L_FI 8'h43
`define L_NO 8'h45
`define L_SE 8'h48
`define L_DE 8'h4b
`define L_FR 8'h52
// Code positions that differ between national sets.
`define NC_HASH 8'h23
`define NC_AT 8'h40
`define NC_LO1 8'h5b
`define NC_HI1 8'h5e
`define NC_GRAVE 8'h60
`define NC_LO2 8'h7b
`define NC_HI2 8'h7e
// Reset values and limits.
`define LINE_ONE 8'h01
`define MAX_LINES 8'ha8
`define FORM_RST 8'h42
`define LAST_ANS 3'h4
`endif

/* File: host_serial_model.sv */
`timescale 1ns/1ps
// Host end of the serial line: sends characters, collects answer bytes.
module host_serial_model (
  input wire clk, // Clock.
  input wire reset, // Reset.
  output logic [7:0] rxData, // Character out.
  output logic rxValid, // Character offered.
  input wire rxReady, // Room at printer.
  input wire [7:0] txData, // Answer byte.
  input wire txValid, // Answer offered.
  output logic txReady, // Answer taken.
  input wire slow // Take answers on alternate cycles.
);
  logic [7:0] ansQ [$];
  logic hung = 1'b0;

  // Idle values at time zero.
  initial
  begin
    rxData = 8'h00;
    rxValid = 1'b0;
  end

  // Hold a byte until taken, then show its inverse so a stale byte is
  // never mistaken for fresh data.
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rxData <= b;
    rxValid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!rxReady && n < 1000);
    hung = hung | !rxReady;
    rxValid <= 1'b0;
    rxData <= ~b;
  endtask

  // Slow mode toggles ready so each answer byte must wait.
  always @(posedge clk)
  begin
    txReady <= reset ? 1'b0 : (slow ? !txReady : 1'b1);
    if (!reset && txValid && txReady)
      ansQ.push_back(txData);
  end
endmodule

/* File: printer_escape_interpreter_properties.sv */
`timescale 1ns/1ps
`include "printer_escape_interpreter_defines.vh"
// Port-level checks of position, print and answer behaviour.
module printer_escape_interpreter_properties (
  input wire clk, // Clock.
  input wire reset, // Reset.
  input wire [7:0] printData, // Code.
  input wire [2:0] printSet, // Set.
  input wire printNational, // Glyph flag.
  input wire [7:0] printCol, // Column.
  input wire printValid, // Print request.
  input wire printReady, // Print taken.
  input wire [7:0] txData, // Answer byte.
  input wire txValid, // Answer valid.
  input wire txReady, // Answer taken.
  input wire bellPulse, // Bell.
  input wire [7:0] bellLine, // Bell line.
  input wire [7:0] activeCol, // Column.
  input wire [7:0] activeLine, // Line.
  input wire [7:0] formLength, // Form.
  input wire [7:0] topMargin, // Top.
  input wire [7:0] bottomMargin, // Bottom.
  input wire [7:0] headCol // Head column.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Codes where national sets may differ from the US set.
  wire natCode = printData == `NC_HASH || printData == `NC_AT ||
    printData == `NC_GRAVE ||
    (printData >= `NC_LO1 && printData <= `NC_HI1) ||
    (printData >= `NC_LO2 && printData <= `NC_HI2);

  a_pos_from_one: assert property (
    activeCol != 8'h00 && activeLine != 8'h00 &&
    (!printValid || printCol != 8'h00))
    else $error("position reads zero");
  a_margin_order: assert property (
    topMargin != 8'h00 && topMargin <= bottomMargin &&
    bottomMargin <= formLength)
    else $error("margins out of order");
  a_line_forward: assert property (
    activeLine < $past(activeLine) |-> activeLine == topMargin)
    else $error("line moved back");
  a_print_hold: assert property (
    printValid && !printReady |=>
    printValid && $stable(printData) && $stable(printCol))
    else $error("stalled print changed");
  a_head_commit: assert property (
    printValid |-> headCol == printCol)
    else $error("head column not committed");
  a_nat_map: assert property (
    printValid |-> printNational == (printSet != `CS_US && natCode))
    else $error("national flag wrong");
  a_bell_line: assert property (
    bellPulse |-> bellLine == activeLine)
    else $error("bell line wrong");
  a_ans_start: assert property (
    $rose(txValid) |-> txData == `CH_ESC)
    else $error("answer starts wrong");
  a_ans_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("answer byte dropped");

  c_answer: cover property (txValid && txReady);
  c_stall: cover property ((printValid && !printReady) [*2]);
  c_bell: cover property (bellPulse);
endmodule

/* File: printer_escape_interpreter_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the escape interpreter.
module printer_escape_interpreter_tb_top;
  localparam [7:0] ID = 8'h5a; // Arbitrary attribute code.
  logic clk, reset, printReady, slow, rxValid, rxReady, txValid, txReady;
  logic [7:0] rxData, printData, printCol, printLine, txData, bellLine;
  logic [7:0] activeCol, activeLine, formLength, topMargin, bottomMargin;
  logic [7:0] headCol, lastData, lastCol, lastLine, bellSeen;
  logic [2:0] printSet, charSet, setupCharset, lastSet;
  logic [1:0] setupNewline;
  logic printValid, printNational, bellPulse, keypadAlt, newlineMode;
  logic idle, lastNat;
  logic [167:0] vtabStops;
  int failures = 0;
  int checks = 0;
  int nPrint = 0;

  printer_escape_interpreter #(.ID_CODE(ID)) u_dut (
    .clk(clk), .reset(reset), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .printData(printData), .printSet(printSet),
    .printNational(printNational), .printCol(printCol),
    .printLine(printLine), .printValid(printValid),
    .printReady(printReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .bellPulse(bellPulse), .bellLine(bellLine),
    .setupNewline(setupNewline), .setupCharset(setupCharset),
    .keypadAlt(keypadAlt), .newlineMode(newlineMode), .charSet(charSet),
    .activeCol(activeCol), .activeLine(activeLine),
    .formLength(formLength), .topMargin(topMargin),
    .bottomMargin(bottomMargin), .headCol(headCol),
    .vtabStops(vtabStops), .idle(idle)
  );

  host_serial_model u_host (
    .clk(clk), .reset(reset), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .slow(slow)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Record each printed code and each bell as the mechanism sees them.
  always @(posedge clk)
  begin
    if (printValid && printReady)
    begin
      nPrint <= nPrint + 1;
      lastData <= printData;
      lastSet <= printSet;
      lastNat <= printNational;
      lastCol <= printCol;
      lastLine <= printLine;
    end
    if (bellPulse)
      bellSeen <= bellLine;
  end

  task automatic chk(input logic [167:0] seen, input logic [167:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for all buffered work to finish; a hang ends the run.
  task automatic settle;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (idle !== 1'b1 && n < 500);
    @(negedge clk);
    if (n >= 500 || u_host.hung)
    begin
      failures++;
      complete_run;
    end
  endtask

  task automatic say(input string s);
    for (int i = 0; i < s.len(); i++)
      u_host.put(s[i]);
    settle;
  endtask

  // Operator levels pass a synchroniser, so allow a few cycles.
  task automatic pick(input logic [1:0] nl, input logic [2:0] cs);
    @(posedge clk);
    setupNewline <= nl;
    setupCharset <= cs;
    repeat (8) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic s_vtab;
    string s;
    s = "\033[";
    chk({activeCol, activeLine}, 16'h0101);
    say("\033J");
    chk(vtabStops, 168'h1);
    say("\n\0333");
    chk(vtabStops, 168'h3);
    say("\033[1g");
    chk(vtabStops, 168'h1);
    say("\033[3;5;7v");
    chk(vtabStops, 168'h55);
    say("\0334");
    chk(vtabStops, 168'h0);
    for (int i = 1; i <= 16; i++)
      s = {s, $sformatf("%0d", i), (i < 16) ? ";" : "v"};
    say(s);
    chk(vtabStops, 168'hffff);
    say("\033[4g");
    chk(vtabStops, 168'h0);
    chk(activeLine, 8'h02);
  endtask

  task automatic s_form;
    say("\033[010t");
    chk({formLength, topMargin}, 16'h0a01);
    chk({bottomMargin, activeLine}, 16'h0a01);
    say("\033[2;5r");
    chk({topMargin, bottomMargin}, 16'h0205);
    say("\033[;7r");
    chk({topMargin, bottomMargin}, 16'h0207);
    say("\033[20t");
    chk({formLength, bottomMargin}, 16'h1414);
    chk({topMargin, activeLine}, 16'h0101);
    say("\033=");
    chk(keypadAlt, 1'b1);
    say("\033>");
    chk(keypadAlt, 1'b0);
  endtask

  task automatic s_mode;
    say("\033[20h");
    chk(newlineMode, 1'b1);
    say("\033[20l");
    chk(newlineMode, 1'b0);
    pick(2'h2, 3'h0);
    chk(newlineMode, 1'b1);
    say("AB\n");
    chk({activeCol, activeLine}, 16'h0102);
    pick(2'h3, 3'h0);
    chk(newlineMode, 1'b0);
    pick(2'h2, 3'h0);
    pick(2'h1, 3'h0);
    chk(newlineMode, 1'b0);
  endtask

  task automatic s_charset;
    logic [7:0] lt [7];
    lt = '{8'h42, 8'h41, 8'h43, 8'h45, 8'h48, 8'h4b, 8'h52};
    for (int i = 0; i < 7; i++)
    begin
      say($sformatf("\033(%c", lt[i]));
      chk(charSet, (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : i[2:0]);
    end
    say("\033(A#");
    chk({lastData, lastSet, lastNat}, 12'h233);
    say("$");
    chk({lastData, lastNat}, 9'h048);
    chk({lastCol, activeCol}, 16'h0203);
    pick(2'h1, 3'h5);
    chk(charSet, 3'h5);
    say("\033(B");
    chk(charSet, 3'h0);
  endtask

  // A stalled mechanism must back up into the buffer without loss.
  task automatic s_stall;
    int n0;
    logic low;
    n0 = nPrint;
    low = 1'b0;
    @(posedge clk);
    printReady <= 1'b0;
    fork
      for (int i = 0; i < 20; i++)
        u_host.put(8'h78);
      begin
        for (int k = 0; k < 200 && rxReady; k++)
          @(negedge clk);
        low = !rxReady;
        @(posedge clk);
        printReady <= 1'b1;
      end
    join
    settle;
    chk(low, 1'b1);
    chk(nPrint - n0, 20);
    chk({headCol, activeCol}, 16'h1617);
  endtask

  task automatic s_rest;
    logic [7:0] e [5];
    e = '{8'h1b, 8'h5b, 8'h3f, ID, 8'h63};
    say("\n\007");
    chk(bellSeen, 8'h03);
    chk({activeCol, activeLine}, 16'h1703);
    say("\033[?5h\033Z\033[5~Q");
    chk({keypadAlt, newlineMode}, 2'b00);
    chk({lastData, lastCol, lastLine}, 24'h51_1703);
    // Vertical tab walks forward to the stop; form feed goes to the top.
    say("\033[9v\013\015  \010");
    chk({activeCol, activeLine}, 16'h0209);
    say("\014");
    chk(activeLine, 8'h01);
    for (int r = 0; r < 2; r++)
    begin
      slow <= (r == 0);
      say((r == 0) ? "\033[c" : "\033[0c");
      chk(u_host.ansQ.size(), 5);
      for (int i = 0; i < 5; i++)
        chk(u_host.ansQ[i], e[i]);
      u_host.ansQ.delete();
    end
  endtask

  initial
  begin
    reset = 1'b1;
    printReady = 1'b1;
    slow = 1'b0;
    setupNewline = 2'h0;
    setupCharset = 3'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    s_vtab;
    s_form;
    s_mode;
    s_charset;
    s_stall;
    s_rest;
    complete_run;
  end
endmodule

bind printer_escape_interpreter
  printer_escape_interpreter_properties u_props (
  .clk(clk), .reset(reset), .printData(printData), .printSet(printSet),
  .printNational(printNational), .printCol(printCol),
  .printValid(printValid), .printReady(printReady), .txData(txData),
  .txValid(txValid), .txReady(txReady), .bellPulse(bellPulse),
  .bellLine(bellLine), .activeCol(activeCol), .activeLine(activeLine),
  .formLength(formLength), .topMargin(topMargin),
  .bottomMargin(bottomMargin), .headCol(headCol)
);
